/* File: include/exc_gate_map.svh */
`ifndef EXC_GATE_MAP_SVH
`define EXC_GATE_MAP_SVH

// Register byte offsets
`define OFS_CTRL       8'h00
`define OFS_STATUS     8'h04
`define OFS_PENDING    8'h08

// Control register fields
`define CTRL_TRAP_LSB  0
`define CTRL_OVR_LSB   4
`define CTRL_RESET     32'h0000_0000

// Exception type index
`define EXC_ABORT      0
`define EXC_IRQ        1
`define EXC_FIQ        2
`define EXC_COUNT      3

// Status register fields
`define STAT_TAKE_LSB  0
`define STAT_MON_LSB   4

// Bus responses
`define RESP_OKAY      2'b00
`define RESP_SLVERR    2'b10

`endif

/* File: include/exc_gate_pkg.sv */
package exc_gate_pkg;

    typedef logic [2:0] exc_vec_t;

    typedef struct packed {
        logic        awHave;
        logic        wHave;
        logic [7:0]  wAddr;
        logic [31:0] wData;
        logic        bValid;
        logic [1:0]  bResp;
        logic        rValid;
        logic [1:0]  rResp;
        logic [31:0] rData;
        exc_vec_t    trapToMonitor;
        exc_vec_t    virtOverride;
        exc_vec_t    take;
        exc_vec_t    toMonitor;
    } state_t;

endpackage : exc_gate_pkg

/* File: src/virtual_exception_gating.sv */
`timescale 1ns/100ps
`include "exc_gate_map.svh"
// Contract
// RULE_01: In Secure state overrides are ignored; status mask alone decides taking.
// RULE_02: Non-secure with trap bit clear: status mask alone decides taking.
// RULE_03: Trap-to-monitor bit set routes that exception to Monitor mode.
// RULE_04: Monitor-routed exceptions: status mask qualified by override bit decides taking; in Secure state the code uses the status mask alone.
// RULE_05: Abort, IRQ, FIQ each use their own trap, mask and override bits.
module virtual_exception_gating (
    input  wire logic                 clock,
    input  wire logic                 rst,
    // Exception sources and core state, index 0 abort, 1 IRQ, 2 FIQ
    input  wire exc_gate_pkg::exc_vec_t excRequest,
    input  wire exc_gate_pkg::exc_vec_t statusMask,
    input  wire logic                 secureState,
    output logic [2:0]                excTake,
    output logic [2:0]                excToMonitor,
    // AXI4-Lite slave
    input  wire logic [7:0]           awaddr,
    input  wire logic                 awvalid,
    output logic                      awready,
    input  wire logic [31:0]          wdata,
    input  wire logic [3:0]           wstrb,
    input  wire logic                 wvalid,
    output logic                      wready,
    output logic [1:0]                bresp,
    output logic                      bvalid,
    input  wire logic                 bready,
    input  wire logic [7:0]           araddr,
    input  wire logic                 arvalid,
    output logic                      arready,
    output logic [31:0]               rdata,
    output logic [1:0]                rresp,
    output logic                      rvalid,
    input  wire logic                 rready
);
    import exc_gate_pkg::*;

    state_t   st_r;
    state_t   st_nxt;
    exc_vec_t takeNxt;
    exc_vec_t monNxt;
    logic     awFire;
    logic     wFire;
    logic     arFire;
    logic [7:0]  curAddr;
    logic [31:0] curData;
    logic [31:0] mergedCtrl;

    // Per-type decision
    genvar i;
    generate
        for (i = 0; i < `EXC_COUNT; i = i + 1) begin : g_exc
            logic effMask;
            always_comb begin
                if (secureState || !st_r.trapToMonitor[i]) begin
                    effMask = statusMask[i]; // RULE_01 RULE_02
                end else begin
                    effMask = statusMask[i] & ~st_r.virtOverride[i]; // RULE_04
                end
            end
            assign takeNxt[i] = excRequest[i] & ~effMask; // RULE_05
            assign monNxt[i]  = excRequest[i] & ~effMask & st_r.trapToMonitor[i]; // RULE_03
        end
    endgenerate

    assign awready = !st_r.awHave && !st_r.bValid;
    assign wready  = !st_r.wHave && !st_r.bValid;
    assign arready = !st_r.rValid;
    assign awFire  = awvalid && awready;
    assign wFire   = wvalid && wready;
    assign arFire  = arvalid && arready;
    assign curAddr = st_r.awHave ? st_r.wAddr : awaddr;
    assign curData = st_r.wHave ? st_r.wData : wdata;

    // Control word with byte-lane merge
    always_comb begin
        mergedCtrl = 32'h0000_0000;
        mergedCtrl[`CTRL_TRAP_LSB +: 3] = st_r.trapToMonitor;
        mergedCtrl[`CTRL_OVR_LSB +: 3]  = st_r.virtOverride;
        if (wstrb[0] || st_r.wHave) begin
            mergedCtrl[7:0] = curData[7:0];
        end
    end

    always_comb begin
        st_nxt           = st_r;
        st_nxt.take      = takeNxt;
        st_nxt.toMonitor = monNxt;
        // Write address and data, either order
        if (awFire) begin
            st_nxt.awHave = 1'b1;
            st_nxt.wAddr  = awaddr;
        end
        if (wFire) begin
            st_nxt.wHave = 1'b1;
            st_nxt.wData = wstrb[0] ? wdata : {24'h0000_00, mergedCtrl[7:0]};
        end
        if ((st_r.awHave || awFire) && (st_r.wHave || wFire)) begin
            st_nxt.awHave = 1'b0;
            st_nxt.wHave  = 1'b0;
            st_nxt.bValid = 1'b1;
            if (curAddr == `OFS_CTRL) begin
                st_nxt.bResp = `RESP_OKAY;
                if (st_r.wHave || wstrb[0]) begin
                    st_nxt.trapToMonitor = curData[`CTRL_TRAP_LSB +: 3];
                    st_nxt.virtOverride  = curData[`CTRL_OVR_LSB +: 3];
                end
            end else if (curAddr == `OFS_STATUS || curAddr == `OFS_PENDING) begin
                st_nxt.bResp = `RESP_OKAY;
            end else begin
                st_nxt.bResp = `RESP_SLVERR;
            end
        end
        if (st_r.bValid && bready) begin
            st_nxt.bValid = 1'b0;
        end
        // Read channel
        if (arFire) begin
            st_nxt.rValid = 1'b1;
            st_nxt.rResp  = `RESP_OKAY;
            st_nxt.rData  = 32'h0000_0000;
            if (araddr == `OFS_CTRL) begin
                st_nxt.rData[`CTRL_TRAP_LSB +: 3] = st_r.trapToMonitor;
                st_nxt.rData[`CTRL_OVR_LSB +: 3]  = st_r.virtOverride;
            end else if (araddr == `OFS_STATUS) begin
                st_nxt.rData[`STAT_TAKE_LSB +: 3] = st_r.take;
                st_nxt.rData[`STAT_MON_LSB +: 3]  = st_r.toMonitor;
            end else if (araddr == `OFS_PENDING) begin
                st_nxt.rData[2:0] = excRequest;
                st_nxt.rData[6:4] = statusMask;
                st_nxt.rData[8]   = secureState;
            end else begin
                st_nxt.rResp = `RESP_SLVERR;
            end
        end else if (st_r.rValid && rready) begin
            st_nxt.rValid = 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign excTake      = st_r.take;
    assign excToMonitor = st_r.toMonitor;
    assign bvalid       = st_r.bValid;
    assign bresp        = st_r.bResp;
    assign rvalid       = st_r.rValid;
    assign rresp        = st_r.rResp;
    assign rdata        = st_r.rData;

endmodule : virtual_exception_gating

/* File: tb/exc_gate_assertions.sv */
`timescale 1ns/100ps
module exc_gate_assertions (
    input wire logic                   clock,
    input wire logic                   rst,
    input wire exc_gate_pkg::exc_vec_t excRequest,
    input wire exc_gate_pkg::exc_vec_t statusMask,
    input wire logic                   secureState,
    input wire logic [2:0]             excTake,
    input wire logic [2:0]             excToMonitor
);
    import exc_gate_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sec_mask_a: assert property (secureState |=> excTake == $past(excRequest & ~statusMask))
        else $error("secure take mismatch");
    open_take_a: assert property (1 |=> (excTake | ~$past(excRequest & ~statusMask)) == 3'h7)
        else $error("unmasked request not taken");
    mon_taken_a: assert property ((excToMonitor & ~excTake) == 3'h0)
        else $error("monitor route without take");
    ovr_pass_a: assert property (##1 (excTake & $past(statusMask) & ~excToMonitor) == 3'h0)
        else $error("masked take outside monitor route");
    own_bit_a: assert property (1 |=> (excTake & ~$past(excRequest)) == 3'h0)
        else $error("take without own request");
endmodule : exc_gate_assertions
bind virtual_exception_gating exc_gate_assertions u_chk (.clock(clock), .rst(rst), .excRequest(excRequest),
    .statusMask(statusMask), .secureState(secureState), .excTake(excTake), .excToMonitor(excToMonitor));

/* File: tb/exc_core_model.sv */
`timescale 1ns/100ps
module exc_core_model (
    input  wire logic              clock,
    input  wire logic [6:0]        cmd,
    output exc_gate_pkg::exc_vec_t excRequest,
    output exc_gate_pkg::exc_vec_t statusMask,
    output logic                   secureState
);
    import exc_gate_pkg::*;
    initial {secureState, statusMask, excRequest} = 7'h00;
    always @(posedge clock) {secureState, statusMask, excRequest} <= cmd;
endmodule : exc_core_model

/* File: tb/testbench.sv */
`timescale 1ns/100ps
`include "exc_gate_map.svh"
module testbench;
    import exc_gate_pkg::*;
    logic clock = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [6:0] cmd = 7'h00;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, secureState, pa, pw;
    logic [1:0] bresp, rresp;
    logic [2:0] excTake, excToMonitor, tr, ov, ex;
    exc_vec_t excRequest, statusMask;
    int nErrors = 0, testsRun = 0, cyc = 0;
    always #10 clock = ~clock;
    exc_core_model u_core (.clock(clock), .cmd(cmd), .excRequest(excRequest), .statusMask(statusMask),
        .secureState(secureState));
    virtual_exception_gating u_dut (.clock(clock), .rst(rst), .excRequest(excRequest), .statusMask(statusMask),
        .secureState(secureState), .excTake(excTake), .excToMonitor(excToMonitor), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        testsRun++;
        if (s !== e) begin
            nErrors++;
            $display("[ERR] %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        {pa, pw} = 2'b11;
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'b111;
        while (pa || pw) begin
            @(posedge clock);
            if (pa && awready) {pa, awvalid} <= 2'b00;
            if (pw && wready) {pw, wvalid} <= 2'b00;
            #1;
        end
        do @(posedge clock); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", bresp, r);
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        do @(posedge clock); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clock); while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk("rdata", rdata, d);
        chk("rresp", rresp, r);
    endtask : rd
    task tallyAndFinish;
        $display("checks %0d mismatches %0d", testsRun, nErrors);
        if (nErrors == 0 && testsRun > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : tallyAndFinish
    always @(posedge clock) begin
        cyc++;
        if (cyc == 40000) begin
            nErrors++;
            tallyAndFinish;
        end
    end
    initial begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd(`OFS_CTRL, `CTRL_RESET, `RESP_OKAY);
        rd(8'h0C, 32'h0000_0000, `RESP_SLVERR);
        wr(8'h0C, 32'h0000_0077, `RESP_SLVERR);
        wr(`OFS_STATUS, 32'h0000_0077, `RESP_OKAY);
        rd(`OFS_CTRL, `CTRL_RESET, `RESP_OKAY);
        $display("bus test done");
        for (int t = 0; t < 64; t++) begin
            {ov, tr} = t[5:0];
            wr(`OFS_CTRL, {25'h0, ov, 1'b0, tr}, `RESP_OKAY);
            rd(`OFS_CTRL, {25'h0, ov, 1'b0, tr}, `RESP_OKAY);
            for (int k = 0; k < 128; k++) begin
                cmd <= k[6:0];
                repeat (3) @(posedge clock);
                #1;
                ex = k[2:0] & ~(k[5:3] & ~(~{3{k[6]}} & tr & ov));
                chk("excTake", excTake, ex);
                chk("excToMonitor", excToMonitor, ex & tr);
            end
        end
        rd(`OFS_STATUS, 32'h0000_0000, `RESP_OKAY);
        rd(`OFS_PENDING, 32'h0000_0177, `RESP_OKAY);
        $display("gating test done");
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        rd(`OFS_CTRL, `CTRL_RESET, `RESP_OKAY);
        $display("reset test done");
        tallyAndFinish;
    end
endmodule : testbench
